/* hw/iosrd_consts.svh */
// register offsets, field masks, reset values and address limits of the io space decoder
`ifndef IOSRD_CONSTS_SVH
`define IOSRD_CONSTS_SVH

// address limits, data-space addresses
`define IOSRD_DATA_OFFSET 9'h020
`define IOSRD_IO_TOP 9'h03f
`define IOSRD_BIT_TOP 9'h01f
`define IOSRD_EXT_BASE 9'h060
`define IOSRD_RESET_VALUE 8'h00

// io offsets
`define IOSRD_PORT_B_IN 6'h03
`define IOSRD_PORT_B_DIR 6'h04
`define IOSRD_PORT_B_OUT 6'h05
`define IOSRD_PORT_C_IN 6'h06
`define IOSRD_PORT_C_DIR 6'h07
`define IOSRD_PORT_C_OUT 6'h08
`define IOSRD_PORT_D_IN 6'h09
`define IOSRD_PORT_D_DIR 6'h0a
`define IOSRD_PORT_D_OUT 6'h0b
`define IOSRD_T0_FLAGS 6'h15
`define IOSRD_T1_FLAGS 6'h16
`define IOSRD_PC_FLAGS 6'h1b
`define IOSRD_EXT_FLAGS 6'h1c
`define IOSRD_EXT_MASK 6'h1d
`define IOSRD_SCRATCH_0 6'h1e
`define IOSRD_EE_CTRL 6'h1f
`define IOSRD_EE_DATA 6'h20
`define IOSRD_EE_ADDR_LO 6'h21
`define IOSRD_EE_ADDR_HI 6'h22
`define IOSRD_PRESCALE 6'h23
`define IOSRD_T0_CTRL_A 6'h24
`define IOSRD_T0_CTRL_B 6'h25
`define IOSRD_T0_COUNT 6'h26
`define IOSRD_T0_CMP_A 6'h27
`define IOSRD_T0_CMP_B 6'h28
`define IOSRD_PLL_CS 6'h29
`define IOSRD_SCRATCH_1 6'h2a
`define IOSRD_SCRATCH_2 6'h2b
`define IOSRD_SPI_CTRL 6'h2c
`define IOSRD_SPI_STAT 6'h2d

// implemented bits per register
`define IOSRD_MASK_FULL 8'hff
`define IOSRD_MASK_PORT_C 8'hf7
`define IOSRD_MASK_EE_CTRL 8'h3f
`define IOSRD_MASK_EE_ADDR_HI 8'h01
`define IOSRD_MASK_PRESCALE 8'h83
`define IOSRD_MASK_T0_CTRL_A 8'hf3
`define IOSRD_MASK_T0_CTRL_B 8'hcf
`define IOSRD_MASK_PLL_CTRL 8'h1e
`define IOSRD_MASK_PLL_LOCK 8'h01
`define IOSRD_MASK_SPI_STAT_CTRL 8'h01
`define IOSRD_MASK_T0_FLAGS 8'h07
`define IOSRD_MASK_T1_FLAGS 8'h2f
`define IOSRD_MASK_PC_FLAGS 8'h03
`define IOSRD_MASK_EXT_FLAGS 8'hff

`endif

/* hw/iosrd_decoder.sv */
// io register space decoder: port, timer, pll, eeprom and serial control registers
`include "iosrd_consts.svh"

module iosrd_decoder
   import iosrd_pkg::*;
#(
   parameter int DATA_ADDR_W = 9
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // core access port
   input wire iosrd_req_t req,
   output iosrd_rsp_t rsp,
   // gpio pins
   input wire iosrd_port_t pins_in,
   output iosrd_port_t port_out,
   output iosrd_port_t port_dir,
   // peripheral events, status and control
   input wire iosrd_flags_t flag_set_evt,
   input wire iosrd_status_t periph_status,
   output iosrd_flags_t flags,
   output iosrd_ctrl_t ctrl
);

   if (DATA_ADDR_W != 9)
   begin : g_bad_addr_w
      $error("core address must be 9 bits wide");
   end

   localparam logic [3:0][5:0] FLAG_IDX =
      {`IOSRD_T0_FLAGS, `IOSRD_T1_FLAGS, `IOSRD_PC_FLAGS, `IOSRD_EXT_FLAGS};
   localparam logic [3:0][7:0] FLAG_MASK = {`IOSRD_MASK_T0_FLAGS, `IOSRD_MASK_T1_FLAGS,
      `IOSRD_MASK_PC_FLAGS, `IOSRD_MASK_EXT_FLAGS};

   iosrd_state_t state;
   iosrd_state_t next_state;
   logic [3:0][7:0] flag_q;
   logic [3:0][7:0] flag_evt;
   logic [3:0][7:0] flag_clr;
   logic dec_hit;
   logic [5:0] dec_idx;
   logic [7:0] rd_val;
   logic [7:0] wr_val;
   logic is_write;
   logic is_bit_op;
   logic is_skip;
   logic [7:0] bit_hot;
   logic [7:0] keep_bit;

   // software-writable bits; zero marks a slot with no storage
   function automatic logic [7:0] wmask(input logic [5:0] idx);
      unique case (idx)
         `IOSRD_PORT_B_DIR, `IOSRD_PORT_B_OUT, `IOSRD_PORT_D_DIR, `IOSRD_PORT_D_OUT,
         `IOSRD_EXT_MASK, `IOSRD_SCRATCH_0, `IOSRD_EE_DATA, `IOSRD_EE_ADDR_LO,
         `IOSRD_T0_COUNT, `IOSRD_T0_CMP_A, `IOSRD_T0_CMP_B, `IOSRD_SCRATCH_1,
         `IOSRD_SCRATCH_2, `IOSRD_SPI_CTRL:
            wmask = `IOSRD_MASK_FULL;
         `IOSRD_PORT_C_DIR, `IOSRD_PORT_C_OUT:
            wmask = `IOSRD_MASK_PORT_C;
         `IOSRD_EE_CTRL:
            wmask = `IOSRD_MASK_EE_CTRL;
         `IOSRD_EE_ADDR_HI:
            wmask = `IOSRD_MASK_EE_ADDR_HI;
         `IOSRD_PRESCALE:
            wmask = `IOSRD_MASK_PRESCALE;
         `IOSRD_T0_CTRL_A:
            wmask = `IOSRD_MASK_T0_CTRL_A;
         `IOSRD_T0_CTRL_B:
            wmask = `IOSRD_MASK_T0_CTRL_B;
         `IOSRD_PLL_CS:
            wmask = `IOSRD_MASK_PLL_CTRL;
         `IOSRD_SPI_STAT:
            wmask = `IOSRD_MASK_SPI_STAT_CTRL;
         default:
            wmask = '0;
      endcase
   endfunction

   // a slot with neither storage nor a live source
   function automatic logic reserved_slot(input logic [5:0] idx);
      reserved_slot = (wmask(idx) == '0) && !(idx inside {`IOSRD_PORT_B_IN,
         `IOSRD_PORT_C_IN, `IOSRD_PORT_D_IN, FLAG_IDX[3], FLAG_IDX[2], FLAG_IDX[1],
         FLAG_IDX[0]});
   endfunction

   // map a core address onto an io slot, {hit, index}
   function automatic logic [6:0] decode_req(input iosrd_req_t r);
      logic [8:0] rel;
      rel = r.addr - `IOSRD_DATA_OFFSET;
      decode_req = '0;
      unique case (r.op)
         data_load_op, data_write_op:
            // core file below, extended region above: no slot here
            if (r.addr >= `IOSRD_DATA_OFFSET && r.addr < `IOSRD_EXT_BASE)
               decode_req = {1'b1, rel[5:0]};
         single_bit_set_op, single_bit_clear_op,
         skip_when_bit_high_op, skip_when_bit_low_op:
            if (r.addr <= `IOSRD_BIT_TOP)
               decode_req = {1'b1, r.addr[5:0]};
         io_read_op, io_write_op:
            if (r.addr <= `IOSRD_IO_TOP)
               decode_req = {1'b1, r.addr[5:0]};
      endcase
   endfunction

   always_comb
   begin
      flag_evt = flag_set_evt;
      {dec_hit, dec_idx} = decode_req(req);
      is_write = req.op inside {io_write_op, data_write_op};
      is_bit_op = req.op inside {single_bit_set_op, single_bit_clear_op};
      is_skip = req.op inside {skip_when_bit_high_op, skip_when_bit_low_op};
      bit_hot = 8'h01 << req.bit_sel;
      // a clear op writes zero back at its own bit, so that one flag survives
      keep_bit = (req.op == single_bit_clear_op) ? bit_hot : 8'h00;
   end

   // read value of the addressed slot; reserved bits read zero
   always_comb
   begin
      rd_val = state.regs[dec_idx] & wmask(dec_idx);
      unique case (dec_idx)
         `IOSRD_PORT_B_IN:
            rd_val = state.pin_sync.b;
         `IOSRD_PORT_C_IN:
            rd_val = state.pin_sync.c & `IOSRD_MASK_PORT_C;
         `IOSRD_PORT_D_IN:
            rd_val = state.pin_sync.d;
         FLAG_IDX[3]:
            rd_val = flag_q[3];
         FLAG_IDX[2]:
            rd_val = flag_q[2];
         FLAG_IDX[1]:
            rd_val = flag_q[1];
         FLAG_IDX[0]:
            rd_val = flag_q[0];
         `IOSRD_PLL_CS:
            rd_val = (state.regs[dec_idx] & `IOSRD_MASK_PLL_CTRL)
               | {7'h00, periph_status.pll_lock};
         `IOSRD_SPI_STAT:
            rd_val = {periph_status.spi_flags, 5'h00,
               state.regs[dec_idx][0]};
         default:
            rd_val = state.regs[dec_idx] & wmask(dec_idx);
      endcase
   end

   // bit operations rewrite the whole register from what was read
   always_comb
   begin
      wr_val = req.wdata;
      if (req.op == single_bit_set_op)
         wr_val = rd_val | (8'h01 << req.bit_sel);
      else if (req.op == single_bit_clear_op)
         wr_val = rd_val & ~(8'h01 << req.bit_sel);
   end

   always_comb
   begin
      next_state = state;
      next_state.pin_meta = pins_in;
      next_state.pin_sync = state.pin_meta;
      next_state.rsp = '0;
      next_state.rsp.ack = req.valid;
      flag_clr = '0;
      if (req.valid && dec_hit)
      begin
         if (is_write || is_bit_op)
         begin
            // slots without storage keep zero, so reserved writes vanish
            next_state.regs[dec_idx] = wr_val & wmask(dec_idx);
            for (int k = 0; k < 4; k++)
            begin
               if (dec_idx == FLAG_IDX[k])
                  flag_clr[k] = wr_val;
            end
         end
         if (req.op inside {io_read_op, data_load_op})
            next_state.rsp.rdata = rd_val;
         if (is_skip)
            next_state.rsp.skip = (req.op == skip_when_bit_high_op)
               ? rd_val[req.bit_sel] : !rd_val[req.bit_sel];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= '0;
      else
         state <= next_state;
   end

   for (genvar g = 0; g < 4; g++)
   begin : g_flags
      iosrd_w1c_flags #(
         .WIDTH(8),
         .VALID_MASK(FLAG_MASK[g])
      ) u_flags (
         .clk(clk),
         .rst_n(rst_n),
         .set_evt(flag_evt[g]),
         .clr(flag_clr[g]),
         .flags(flag_q[g])
      );
   end

   assign flags = flag_q;
   assign rsp = state.rsp;
   assign port_out = '{b: state.regs[`IOSRD_PORT_B_OUT], c: state.regs[`IOSRD_PORT_C_OUT],
      d: state.regs[`IOSRD_PORT_D_OUT]};
   assign port_dir = '{b: state.regs[`IOSRD_PORT_B_DIR], c: state.regs[`IOSRD_PORT_C_DIR],
      d: state.regs[`IOSRD_PORT_D_DIR]};
   assign ctrl = '{
      ext_int_mask: state.regs[`IOSRD_EXT_MASK],
      scratch_0: state.regs[`IOSRD_SCRATCH_0],
      eeprom_control: state.regs[`IOSRD_EE_CTRL],
      eeprom_data: state.regs[`IOSRD_EE_DATA],
      eeprom_address_low: state.regs[`IOSRD_EE_ADDR_LO],
      eeprom_address_high: state.regs[`IOSRD_EE_ADDR_HI],
      timer_prescaler_control: state.regs[`IOSRD_PRESCALE],
      timer0_control_a: state.regs[`IOSRD_T0_CTRL_A],
      timer0_control_b: state.regs[`IOSRD_T0_CTRL_B],
      timer0_count: state.regs[`IOSRD_T0_COUNT],
      timer0_compare_a: state.regs[`IOSRD_T0_CMP_A],
      timer0_compare_b: state.regs[`IOSRD_T0_CMP_B],
      pll_control: state.regs[`IOSRD_PLL_CS],
      scratch_1: state.regs[`IOSRD_SCRATCH_1],
      scratch_2: state.regs[`IOSRD_SCRATCH_2],
      serial_periph_control: state.regs[`IOSRD_SPI_CTRL],
      serial_periph_status: state.regs[`IOSRD_SPI_STAT]};

   // checks on the core-facing behaviour

   sequence s_low_bit_op;
      req.valid && is_bit_op && req.addr <= `IOSRD_BIT_TOP;
   endsequence

   sequence s_flag_slot_quiet;
      (dec_idx == `IOSRD_T0_FLAGS) && (flag_set_evt.timer0 == '0);
   endsequence

   property p_bit_set_lands;
      @(posedge clk) disable iff (!rst_n)
      s_low_bit_op ##0 (req.op == single_bit_set_op)
         ##0 ((wmask(dec_idx) & bit_hot) != 8'h00)
      |=> state.regs[$past(dec_idx)][$past(req.bit_sel)] && rsp.ack;
   endproperty
   a_bit_set_lands: assert property (p_bit_set_lands)
      else $error("bit set did not reach the register");

   property p_bit_op_high_refused;
      @(posedge clk) disable iff (!rst_n)
      req.valid && (is_bit_op || is_skip) && req.addr > `IOSRD_BIT_TOP
      |=> state.regs == $past(state.regs) && !rsp.skip && rsp.ack;
   endproperty
   a_bit_op_high_refused: assert property (p_bit_op_high_refused)
      else $error("bit operation acted above the bit range");

   property p_skip_tests_bit;
      @(posedge clk) disable iff (!rst_n)
      req.valid && is_skip && req.addr <= `IOSRD_BIT_TOP
      |=> rsp.ack && (rsp.skip == ((($past(rd_val) & $past(bit_hot)) != 8'h00)
         == ($past(req.op) == skip_when_bit_high_op)));
   endproperty
   a_skip_tests_bit: assert property (p_skip_tests_bit)
      else $error("skip answer does not match the tested bit");

   property p_rmw_clears_flags;
      @(posedge clk) disable iff (!rst_n)
      s_low_bit_op ##0 s_flag_slot_quiet ##1 (flag_set_evt.timer0 == '0)
      |=> (flags.timer0 & ~$past(keep_bit, 2)) == 8'h00;
   endproperty
   a_rmw_clears_flags: assert property (p_rmw_clears_flags)
      else $error("bit operation left a flag set");

   property p_data_offset;
      @(posedge clk) disable iff (!rst_n)
      req.valid && req.op == data_write_op
         && req.addr == ({3'h0, `IOSRD_PORT_B_OUT} + `IOSRD_DATA_OFFSET)
      |=> port_out.b == $past(req.wdata) ##1 port_out.b == $past(req.wdata, 2)
         || $past(req.valid);
   endproperty
   a_data_offset: assert property (p_data_offset)
      else $error("data-space write missed the offset register");

   property p_io_write_direct;
      @(posedge clk) disable iff (!rst_n)
      req.valid && req.op == io_write_op && req.addr == {3'h0, `IOSRD_PORT_D_DIR}
      |=> port_dir.d == $past(req.wdata);
   endproperty
   a_io_write_direct: assert property (p_io_write_direct)
      else $error("io write missed its register");

   property p_ext_only_data;
      @(posedge clk) disable iff (!rst_n)
      req.valid && (req.addr >= `IOSRD_EXT_BASE || (req.addr > `IOSRD_IO_TOP
         && req.op inside {io_read_op, io_write_op}))
      |=> rsp.ack && rsp.rdata == 8'h00 && state.regs == $past(state.regs);
   endproperty
   a_ext_only_data: assert property (p_ext_only_data)
      else $error("io operation reached the extended region");

   property p_reserved_bits_zero;
      @(posedge clk) disable iff (!rst_n)
      req.valid && req.op == io_write_op && req.addr == {3'h0, `IOSRD_PORT_C_OUT}
      |=> port_out.c == ($past(req.wdata) & `IOSRD_MASK_PORT_C);
   endproperty
   a_reserved_bits_zero: assert property (p_reserved_bits_zero)
      else $error("reserved bit took a written value");

   property p_reserved_slot_inert;
      @(posedge clk) disable iff (!rst_n)
      req.valid && dec_hit && reserved_slot(dec_idx)
      |=> state.regs == $past(state.regs) && rsp.rdata == 8'h00;
   endproperty
   a_reserved_slot_inert: assert property (p_reserved_slot_inert)
      else $error("reserved address was not inert");

   property p_bit_clear_lands;
      @(posedge clk) disable iff (!rst_n)
      s_low_bit_op ##0 (req.op == single_bit_clear_op)
         ##0 ((wmask(dec_idx) & bit_hot) != 8'h00)
      |=> !state.regs[$past(dec_idx)][$past(req.bit_sel)] && rsp.ack;
   endproperty
   a_bit_clear_lands: assert property (p_bit_clear_lands)
      else $error("bit clear did not reach the register");

   property p_pin_reserved_bit;
      @(posedge clk) disable iff (!rst_n)
      req.valid && req.op == io_read_op && req.addr == {3'h0, `IOSRD_PORT_C_IN}
      |=> rsp.ack && (rsp.rdata & ~`IOSRD_MASK_PORT_C) == 8'h00;
   endproperty
   a_pin_reserved_bit: assert property (p_pin_reserved_bit)
      else $error("reserved pin bit read as one");

endmodule

/* hw/iosrd_pkg.sv */
// types shared by the io space decoder and its flag registers
package iosrd_pkg;

   typedef enum logic [2:0]
   {
      io_read_op,
      io_write_op,
      data_load_op,
      data_write_op,
      single_bit_set_op,
      single_bit_clear_op,
      skip_when_bit_high_op,
      skip_when_bit_low_op
   } iosrd_op_t;

   typedef struct packed {
      logic valid;
      iosrd_op_t op;
      logic [8:0] addr;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } iosrd_req_t;

   typedef struct packed {
      logic ack;
      logic [7:0] rdata;
      logic skip;
   } iosrd_rsp_t;

   typedef struct packed {
      logic [7:0] b;
      logic [7:0] c;
      logic [7:0] d;
   } iosrd_port_t;

   typedef struct packed {
      logic [7:0] timer0;
      logic [7:0] timer1;
      logic [7:0] pin_change;
      logic [7:0] ext_int;
   } iosrd_flags_t;

   typedef struct packed {
      logic pll_lock;
      logic [1:0] spi_flags;
   } iosrd_status_t;

   typedef struct packed {
      logic [7:0] ext_int_mask;
      logic [7:0] scratch_0;
      logic [7:0] eeprom_control;
      logic [7:0] eeprom_data;
      logic [7:0] eeprom_address_low;
      logic [7:0] eeprom_address_high;
      logic [7:0] timer_prescaler_control;
      logic [7:0] timer0_control_a;
      logic [7:0] timer0_control_b;
      logic [7:0] timer0_count;
      logic [7:0] timer0_compare_a;
      logic [7:0] timer0_compare_b;
      logic [7:0] pll_control;
      logic [7:0] scratch_1;
      logic [7:0] scratch_2;
      logic [7:0] serial_periph_control;
      logic [7:0] serial_periph_status;
   } iosrd_ctrl_t;

   typedef struct packed {
      logic [63:0][7:0] regs;
      iosrd_port_t pin_meta;
      iosrd_port_t pin_sync;
      iosrd_rsp_t rsp;
   } iosrd_state_t;

endpackage

/* hw/iosrd_w1c_flags.sv */
// one status register of sticky flags, set by hardware, cleared by writing one
module iosrd_w1c_flags
   import iosrd_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] VALID_MASK = '1
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // hardware events and software clear strobes
   input wire logic [WIDTH-1:0] set_evt,
   input wire logic [WIDTH-1:0] clr,
   // flag state
   output logic [WIDTH-1:0] flags
);

   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } iosrd_flag_state_t;

   iosrd_flag_state_t state;
   iosrd_flag_state_t next_state;

   if (WIDTH < 1 || WIDTH > 8)
   begin : g_bad_width
      $error("flag register width must be 1 to 8");
   end

   // set wins over a clear arriving in the same cycle
   always_comb
   begin
      next_state.flags = ((state.flags & ~clr) | set_evt) & VALID_MASK;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= '0;
      else
         state <= next_state;
   end

   assign flags = state.flags;

   property p_w1c_clears;
      @(posedge clk) disable iff (!rst_n)
      (clr != '0) ##0 ((clr & set_evt) == '0) |=> ((flags & $past(clr)) == '0);
   endproperty
   a_w1c_clears: assert property (p_w1c_clears)
      else $error("written-one flag did not clear");

   property p_set_wins;
      @(posedge clk) disable iff (!rst_n)
      (set_evt & VALID_MASK) != '0 |=> ((flags & $past(set_evt) & VALID_MASK)
         == ($past(set_evt) & VALID_MASK));
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("flag event lost against a clear");

endmodule

/* tb/iosrd_core_model.sv */
// core-side model issuing io, bit, skip and data-space accesses
module iosrd_core_model
   import iosrd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // access port
   output iosrd_req_t req,
   input wire iosrd_rsp_t rsp
);
   timeunit 1ns;
   timeprecision 100ps;

   initial req = '0;

   // one request per call, taken at the next edge, answer sampled once it has landed
   task automatic access(input iosrd_op_t op, input logic [8:0] addr, input logic [2:0] bit_sel,
      input logic [7:0] wdata, output logic [7:0] rdata, output logic skip, output logic ack);
      wait (rst_n);
      @(posedge clk);
      #1;
      // callers keep reserved bits at zero unless a refusal is under
      req = '{valid: 1'b1, op: op, addr: addr, bit_sel: bit_sel, wdata: wdata};
      @(posedge clk);
      #1;
      ack = rsp.ack;
      rdata = rsp.rdata;
      skip = rsp.skip;
      // released address, bit and data fields show inverted values so a stale bus never passes for a live one
      req = '{valid: 1'b0, op: op, addr: ~addr, bit_sel: ~bit_sel, wdata: ~wdata};
   endtask
endmodule

/* tb/iosrd_decoder_tb.sv */
// self-checking bench for the io space decoder
module iosrd_decoder_tb
   import iosrd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk;
   logic rst_n;
   iosrd_req_t req;
   iosrd_rsp_t rsp;
   iosrd_port_t pins_in;
   iosrd_port_t port_out;
   iosrd_port_t port_dir;
   iosrd_flags_t flag_set_evt;
   iosrd_status_t periph_status;
   iosrd_flags_t flags;
   iosrd_ctrl_t ctrl;
   logic [7:0] rd;
   logic sk;
   logic ak;
   int errors = 0;
   int cmp_count = 0;

   iosrd_decoder #(.DATA_ADDR_W(9)) dut (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp),
      .pins_in(pins_in), .port_out(port_out), .port_dir(port_dir),
      .flag_set_evt(flag_set_evt), .periph_status(periph_status), .flags(flags), .ctrl(ctrl));

   iosrd_core_model core (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic acc(input iosrd_op_t op, input logic [8:0] a, input logic [2:0] b,
      input logic [7:0] w);
      core.access(op, a, b, w, rd, sk, ak);
      chk8({7'h00, ak}, 8'h01);
   endtask

   task automatic pulse_flags(input iosrd_flags_t f);
      @(posedge clk);
      #1;
      flag_set_evt = f;
      @(posedge clk);
      #1;
      flag_set_evt = '0;
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic t_reset;
      chk8(port_out.b, 8'h00);
      chk8(flags.ext_int, 8'h00);
      acc(io_read_op, 9'h005, 3'd0, 8'h00);
      chk8(rd, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_io_map;
      acc(data_write_op, 9'h025, 3'd0, 8'h5a);
      chk8(port_out.b, 8'h5a);
      acc(io_write_op, 9'h005, 3'd0, 8'ha5);
      chk8(port_out.b, 8'ha5);
      acc(data_load_op, 9'h025, 3'd0, 8'h00);
      chk8(rd, 8'ha5);
      acc(data_write_op, 9'h04c, 3'd0, 8'h5c);
      chk8(ctrl.serial_periph_control, 8'h5c);
      acc(io_read_op, 9'h02c, 3'd0, 8'h00);
      chk8(rd, 8'h5c);
      acc(data_load_op, 9'h005, 3'd0, 8'h00);
      chk8(rd, 8'h00);
      acc(io_write_op, 9'h045, 3'd0, 8'hff);
      chk8(port_out.b, 8'ha5);
      acc(io_write_op, 9'h00a, 3'd0, 8'h69);
      chk8(port_dir.d, 8'h69);
      acc(data_write_op, 9'h02b, 3'd0, 8'h96);
      chk8(port_out.d, 8'h96);
      pins_in.d = 8'h3c;
      repeat (2) @(posedge clk);
      acc(io_read_op, 9'h009, 3'd0, 8'h00);
      chk8(rd, 8'h3c);
      $display("test io_map done");
   endtask

   task automatic t_bit_ops;
      logic [7:0] v;
      v = 8'ha4;
      acc(single_bit_set_op, 9'h004, 3'd2, 8'h00);
      chk8(port_dir.b, 8'h04);
      acc(single_bit_set_op, 9'h01e, 3'd7, 8'h00);
      chk8(ctrl.scratch_0, 8'h80);
      acc(single_bit_clear_op, 9'h005, 3'd0, 8'h00);
      chk8(port_out.b, v);
      for (int i = 0; i < 8; i++)
      begin
         acc(skip_when_bit_high_op, 9'h005, i[2:0], 8'h00);
         chk8({7'h00, sk}, {7'h00, v[i]});
         acc(skip_when_bit_low_op, 9'h005, i[2:0], 8'h00);
         chk8({7'h00, sk}, {7'h00, ~v[i]});
      end
      acc(single_bit_set_op, 9'h020, 3'd0, 8'h00);
      chk8(ctrl.eeprom_data, 8'h00);
      acc(io_write_op, 9'h020, 3'd0, 8'hff);
      chk8(ctrl.eeprom_data, 8'hff);
      acc(skip_when_bit_high_op, 9'h020, 3'd0, 8'h00);
      chk8({7'h00, sk}, 8'h00);
      $display("test bit_ops done");
   endtask

   task automatic t_w1c;
      pulse_flags('{timer0: 8'h00, timer1: 8'h00, pin_change: 8'h00, ext_int: 8'h05});
      chk8(flags.ext_int, 8'h05);
      acc(io_write_op, 9'h01c, 3'd0, 8'h01);
      chk8(flags.ext_int, 8'h04);
      acc(io_read_op, 9'h01c, 3'd0, 8'h00);
      chk8(rd, 8'h04);
      acc(skip_when_bit_high_op, 9'h01c, 3'd2, 8'h00);
      chk8({7'h00, sk}, 8'h01);
      acc(single_bit_clear_op, 9'h01c, 3'd6, 8'h00);
      chk8(flags.ext_int, 8'h00);
      pulse_flags('{timer0: 8'hff, timer1: 8'h00, pin_change: 8'h00, ext_int: 8'h00});
      chk8(flags.timer0, 8'h07);
      acc(single_bit_set_op, 9'h015, 3'd1, 8'h00);
      chk8(flags.timer0, 8'h00);
      acc(io_write_op, 9'h01d, 3'd0, 8'h11);
      acc(single_bit_set_op, 9'h01d, 3'd3, 8'h00);
      chk8(ctrl.ext_int_mask, 8'h19);
      // event and clear land on the same edge: the event must win
      fork
         pulse_flags('{timer0: 8'h00, timer1: 8'hff, pin_change: 8'h03, ext_int: 8'h00});
         acc(io_write_op, 9'h01b, 3'd0, 8'h01);
      join
      chk8(flags.pin_change, 8'h03);
      chk8(flags.timer1, 8'h2f);
      acc(io_write_op, 9'h01b, 3'd0, 8'h03);
      chk8(flags.pin_change, 8'h00);
      $display("test w1c done");
   endtask

   task automatic t_masks;
      acc(io_write_op, 9'h01f, 3'd0, 8'hff);
      chk8(ctrl.eeprom_control, 8'h3f);
      acc(io_write_op, 9'h022, 3'd0, 8'hff);
      chk8(ctrl.eeprom_address_high, 8'h01);
      acc(io_write_op, 9'h023, 3'd0, 8'hff);
      chk8(ctrl.timer_prescaler_control, 8'h83);
      acc(io_write_op, 9'h024, 3'd0, 8'hff);
      chk8(ctrl.timer0_control_a, 8'hf3);
      acc(data_write_op, 9'h045, 3'd0, 8'hff);
      chk8(ctrl.timer0_control_b, 8'hcf);
      acc(io_write_op, 9'h007, 3'd0, 8'hff);
      chk8(port_dir.c, 8'hf7);
      acc(io_write_op, 9'h02d, 3'd0, 8'hff);
      chk8(ctrl.serial_periph_status, 8'h01);
      periph_status = '{pll_lock: 1'b0, spi_flags: 2'h2};
      acc(io_read_op, 9'h02d, 3'd0, 8'h00);
      chk8(rd, 8'h81);
      acc(io_read_op, 9'h029, 3'd0, 8'h00);
      chk8(rd, 8'h1e);
      chk8(ctrl.pll_control, 8'h1e);
      acc(data_write_op, 9'h041, 3'd0, 8'h66);
      acc(data_write_op, 9'h046, 3'd0, 8'h11);
      acc(data_write_op, 9'h047, 3'd0, 8'h22);
      acc(data_write_op, 9'h048, 3'd0, 8'h33);
      acc(data_write_op, 9'h04a, 3'd0, 8'h44);
      chk8(ctrl.eeprom_address_low, 8'h66);
      chk8(ctrl.timer0_count, 8'h11);
      chk8(ctrl.timer0_compare_a, 8'h22);
      chk8(ctrl.timer0_compare_b, 8'h33);
      chk8(ctrl.scratch_1, 8'h44);
      acc(io_write_op, 9'h02b, 3'd0, 8'h55);
      chk8(ctrl.scratch_2, 8'h55);
      $display("test masks done");
   endtask

   task automatic t_reserved;
      acc(io_write_op, 9'h010, 3'd0, 8'hff);
      acc(io_read_op, 9'h010, 3'd0, 8'h00);
      chk8(rd, 8'h00);
      acc(data_write_op, 9'h060, 3'd0, 8'h77);
      acc(data_load_op, 9'h060, 3'd0, 8'h00);
      chk8(rd, 8'h00);
      acc(data_load_op, 9'h1ff, 3'd0, 8'h00);
      chk8(rd, 8'h00);
      acc(io_write_op, 9'h008, 3'd0, 8'hff);
      chk8(port_out.c, 8'hf7);
      acc(io_read_op, 9'h008, 3'd0, 8'h00);
      chk8(rd, 8'hf7);
      acc(io_write_op, 9'h029, 3'd0, 8'hff);
      acc(io_read_op, 9'h029, 3'd0, 8'h00);
      chk8(rd, 8'h1f);
      pins_in.c = 8'hff;
      repeat (2) @(posedge clk);
      acc(io_read_op, 9'h006, 3'd0, 8'h00);
      chk8(rd, 8'hf7);
      $display("test reserved done");
   endtask

   initial
   begin
      // a hang in the access port is cut short here
      #50us;
      errors++;
      end_of_test();
   end

   initial
   begin
      rst_n = 1'b0;
      pins_in = '0;
      flag_set_evt = '0;
      periph_status = '{pll_lock: 1'b1, spi_flags: 2'h0};
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_io_map();
      t_bit_ops();
      t_w1c();
      t_reserved();
      t_masks();
      end_of_test();
   end
endmodule
